/* File: hw/gvf_map.vh */
`ifndef GVF_MAP_VH
`define GVF_MAP_VH
// =====================================================
// register offsets
`define GVF_CTRL_OFS      8'h00
`define GVF_IRQ_STAT_OFS  8'h04
`define GVF_IRQ_MASK_OFS  8'h08
`define GVF_ANGLE_IN_OFS  8'h0C
`define GVF_TEMP_IN_OFS   8'h10
`define GVF_DEPTH_IN_OFS  8'h14
`define GVF_DEPTH_FLG_OFS 8'h18
`define GVF_CHG_IN_OFS    8'h1C
`define GVF_ENG1_IN_OFS   8'h20
`define GVF_ENG2_IN_OFS   8'h24
`define GVF_TOD_OFS       8'h28
`define GVF_DATE_OFS      8'h2C
`define GVF_ANGLE_OUT_OFS 8'h30
`define GVF_TFINE_OFS     8'h34
`define GVF_TMC_OFS       8'h38
`define GVF_DRANGE_OFS    8'h3C
`define GVF_CHG_OUT_OFS   8'h40
`define GVF_ENG_OUT_OFS   8'h44
// =====================================================
// field positions and reset values
`define GVF_CTRL_RUN_BIT  0
`define GVF_DFLG_ERR_BIT  0
`define GVF_DFLG_NA_BIT   1
`define GVF_IRQ_DAY_BIT   0
`define GVF_IRQ_SHUT_BIT  1
`define GVF_IRQ_DEPTH_BIT 2
`define GVF_CTRL_RST      32'h00000001
`define GVF_DFLG_RST      2'h2
`define GVF_ENG2_USED     16'h00FF
`define GVF_SHUT_BIT      7
// =====================================================
// format constants
`define GVF_KELVIN_MILLI  32'h00042AFE
`define GVF_TWO_PI_MICRO  32'h005FDFB1
`define GVF_DEPTH_NA      8'hFF
`define GVF_DEPTH_ERR     8'hFE
`define GVF_DEPTH_DEEP    8'hFD
`define GVF_DEPTH_MAXSTEP 32'h000000FC
`define GVF_TENTHS_DAY    32'h000D2F00
`define GVF_DIV10_MUL     64'h00000000CCCCCCCD
`define GVF_DIV10_SH      35
`define GVF_DIV100_MUL    64'h0000000051EB851F
`define GVF_DIV100_SH     37
`define GVF_DIV1000_MUL   64'h0000000010624DD3
`define GVF_DIV1000_SH    38
// =====================================================
// timing
`define GVF_CLK_PERIOD_NS 5
`define GVF_TICK_NS       100000000
`define GVF_TICK_CYC      (`GVF_TICK_NS / `GVF_CLK_PERIOD_NS)
`endif

/* File: hw/gvf_codec.v */
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "gvf_map.vh"
module gvf_codec #(
  parameter integer TICK_CYC = `GVF_TICK_CYC
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  output reg  [15:0] angle_signed_word,
  output reg  [15:0] angle_unsigned_word,
  output reg  [23:0] temp_fine_word,
  output reg  [15:0] temp_medium_word,
  output reg  [15:0] temp_coarse_word,
  output reg  [7:0]  depth_range_word,
  output reg  [15:0] date_word,
  output reg  [31:0] tod_word,
  output reg  [15:0] charger_word,
  output reg  [15:0] engine1_word,
  output reg  [15:0] engine2_word
);

  // =====================================================
  // exact constant division by reciprocal multiply
  function [31:0] div_by;
    input [31:0] x;
    input [1:0]  k;
    reg   [63:0] p;
    begin
      p = 64'h0;
      case (k)
        2'h0:    p = ({32'h0, x} * `GVF_DIV10_MUL) >> `GVF_DIV10_SH;
        2'h1:    p = ({32'h0, x} * `GVF_DIV100_MUL) >> `GVF_DIV100_SH;
        default: p = ({32'h0, x} * `GVF_DIV1000_MUL) >> `GVF_DIV1000_SH;
      endcase
      div_by = p[31:0];
    end
  endfunction

  // =====================================================
  // clamp an unsigned quotient into a 16-bit field
  function [15:0] sat16;
    input [31:0] x;
    begin
      if (x > 32'h0000FFFF) begin
        sat16 = 16'hFFFF;
      end else begin
        sat16 = x[15:0];
      end
    end
  endfunction

  // =====================================================
  // software registers
  reg [31:0] ctrl_reg;
  reg [2:0]  irq_stat_reg;
  reg [2:0]  irq_mask_reg;
  reg [31:0] angle_in_reg;
  reg [31:0] temp_in_reg;
  reg [31:0] depth_in_reg;
  reg [1:0]  depth_flg_reg;
  reg [15:0] chg_in_reg;
  reg [15:0] eng1_in_reg;
  reg [15:0] eng2_in_reg;
  reg [31:0] tick_cnt_reg;
  reg        shut_prev_reg;
  reg        deep_prev_reg;

  wire       acc   = psel & penable & pready;
  wire       wr_en = acc & pwrite;
  wire       run   = ctrl_reg[`GVF_CTRL_RUN_BIT];
  wire       setup   = psel & ~penable;
  wire       wr_tod  = wr_en && (paddr == `GVF_TOD_OFS);
  wire       wr_date = wr_en && (paddr == `GVF_DATE_OFS);
  wire       wr_stat = wr_en && (paddr == `GVF_IRQ_STAT_OFS);

  // =====================================================
  // time of day and date
  // the tick divider is a parameter so a simulation need not wait 100 ms
  wire tick     = run && (tick_cnt_reg == TICK_CYC - 1);
  wire day_wrap = tick && (tod_word == `GVF_TENTHS_DAY - 32'h1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 32'h0;
    end else if (!run || tick) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tod_word  <= 32'h0;
      date_word <= 16'h0;
    end else begin
      if (wr_tod) begin
        tod_word <= pwdata;
      end else if (day_wrap) begin
        tod_word <= 32'h0;
      end else if (tick) begin
        tod_word <= tod_word + 32'h1;
      end
      if (wr_date) begin
        date_word <= pwdata[15:0];
      end else if (day_wrap) begin
        date_word <= date_word + 16'h1;
      end
    end
  end

  // =====================================================
  // angle: input in signed microradians
  reg [31:0] ang_mag;
  reg [31:0] ang_q;
  reg [31:0] ang_wrap;
  reg [31:0] ang_uq;
  reg [15:0] ang_s_next;
  reg [15:0] ang_u_next;
  always @* begin
    ang_mag  = angle_in_reg[31] ? (32'h0 - angle_in_reg) : angle_in_reg;
    ang_q    = div_by(ang_mag, 2'h1);
    if (ang_q > 32'h00007FFF) begin
      ang_q = 32'h00007FFF;
    end
    ang_s_next = angle_in_reg[31] ? (16'h0 - ang_q[15:0]) : ang_q[15:0];
    ang_wrap = angle_in_reg[31] ? (angle_in_reg + `GVF_TWO_PI_MICRO) : angle_in_reg;
    if (ang_wrap[31]) begin
      ang_wrap = 32'h0;
    end
    ang_uq = div_by(ang_wrap, 2'h1);
    ang_u_next = sat16(ang_uq);
  end

  // =====================================================
  // temperature: input in signed milli-degrees Celsius
  reg [31:0] tk_milli;
  reg [23:0] tfine_next;
  reg [31:0] tmed;
  reg [31:0] tcoarse;
  always @* begin
    tk_milli = temp_in_reg + `GVF_KELVIN_MILLI;
    // a large positive reading must not wrap into the below-zero clamp
    if (!temp_in_reg[31] && tk_milli[31]) begin
      tk_milli = 32'h7FFFFFFF;
    end else if (tk_milli[31]) begin
      tk_milli = 32'h0;
    end
    // below absolute zero clamps to zero, above the field clamps to all ones
    tfine_next = (tk_milli > 32'h00FFFFFF) ? 24'hFFFFFF : tk_milli[23:0];
    tmed       = div_by(tk_milli, 2'h0);
    tcoarse    = div_by(tk_milli, 2'h1);
  end

  // =====================================================
  // depth range: input in centimetres
  reg [31:0] dsteps;
  reg [7:0]  drange_next;
  always @* begin
    dsteps = div_by(depth_in_reg, 2'h2);
    if (depth_flg_reg[`GVF_DFLG_NA_BIT]) begin
      drange_next = `GVF_DEPTH_NA;
    end else if (depth_flg_reg[`GVF_DFLG_ERR_BIT]) begin
      drange_next = `GVF_DEPTH_ERR;
    end else if (dsteps > `GVF_DEPTH_MAXSTEP) begin
      drange_next = `GVF_DEPTH_DEEP;
    end else begin
      drange_next = dsteps[7:0];
    end
  end

  // =====================================================
  // named flags of the engine alarm words
  // one wire per flag keeps each bit position visible at a glance
  wire eng1_check_engine                = eng1_in_reg[0];
  wire eng1_over_temperature            = eng1_in_reg[1];
  wire eng1_low_oil_pressure            = eng1_in_reg[2];
  wire eng1_low_oil_level               = eng1_in_reg[3];
  wire eng1_low_fuel_pressure           = eng1_in_reg[4];
  wire eng1_low_system_voltage          = eng1_in_reg[5];
  wire eng1_low_coolant_level           = eng1_in_reg[6];
  wire eng1_water_flow                  = eng1_in_reg[7];
  wire eng1_water_in_fuel               = eng1_in_reg[8];
  wire eng1_charge_indicator            = eng1_in_reg[9];
  wire eng1_preheat                     = eng1_in_reg[10];
  wire eng1_high_boost                  = eng1_in_reg[11];
  wire eng1_rev_limit                   = eng1_in_reg[12];
  wire eng1_exhaust_recirculation_fault = eng1_in_reg[13];
  wire eng1_throttle_sensor_fault       = eng1_in_reg[14];
  wire eng1_emergency_stop              = eng1_in_reg[15];

  wire eng2_warn_level_one              = eng2_in_reg[0];
  wire eng2_warn_level_two              = eng2_in_reg[1];
  wire eng2_power_reduction             = eng2_in_reg[2];
  wire eng2_maint_needed                = eng2_in_reg[3];
  wire eng2_comm_error                  = eng2_in_reg[4];
  wire eng2_second_throttle             = eng2_in_reg[5];
  wire eng2_neutral_protect             = eng2_in_reg[6];
  wire eng2_shutting_down               = eng2_in_reg[`GVF_SHUT_BIT];

  wire [15:0] eng1_flags = {eng1_emergency_stop, eng1_throttle_sensor_fault,
                            eng1_exhaust_recirculation_fault, eng1_rev_limit,
                            eng1_high_boost, eng1_preheat, eng1_charge_indicator,
                            eng1_water_in_fuel, eng1_water_flow, eng1_low_coolant_level,
                            eng1_low_system_voltage, eng1_low_fuel_pressure,
                            eng1_low_oil_level, eng1_low_oil_pressure,
                            eng1_over_temperature, eng1_check_engine};
  // bits 15..8 of word two are unassigned and read as zero
  wire [15:0] eng2_flags = {8'h00, eng2_shutting_down, eng2_neutral_protect,
                            eng2_second_throttle, eng2_comm_error, eng2_maint_needed,
                            eng2_power_reduction, eng2_warn_level_two,
                            eng2_warn_level_one} & `GVF_ENG2_USED;

  // =====================================================
  // charger status fields; codes above ten pass through unchanged
  wire [7:0] chg_converter = chg_in_reg[7:0];
  wire [1:0] chg_thermal   = chg_in_reg[9:8];
  wire [1:0] chg_overload  = chg_in_reg[11:10];
  wire [1:0] chg_low_dc    = chg_in_reg[13:12];
  wire [1:0] chg_ripple    = chg_in_reg[15:14];

  wire shut_now = eng2_shutting_down;
  wire deep_now = (drange_next == `GVF_DEPTH_DEEP) || (drange_next == `GVF_DEPTH_ERR);

  // =====================================================
  // formatted output words, one cycle after their inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      angle_signed_word   <= 16'h0;
      angle_unsigned_word <= 16'h0;
      temp_fine_word      <= 24'h0;
      temp_medium_word    <= 16'h0;
      temp_coarse_word    <= 16'h0;
      depth_range_word    <= `GVF_DEPTH_NA;
      charger_word        <= 16'h0;
      engine1_word        <= 16'h0;
      engine2_word        <= 16'h0;
    end else begin
      angle_signed_word   <= ang_s_next;
      angle_unsigned_word <= ang_u_next;
      temp_fine_word      <= tfine_next;
      temp_medium_word    <= sat16(tmed);
      temp_coarse_word    <= sat16(tcoarse);
      depth_range_word    <= drange_next;
      charger_word[7:0]   <= chg_converter;
      charger_word[9:8]   <= chg_thermal;
      charger_word[11:10] <= chg_overload;
      charger_word[13:12] <= chg_low_dc;
      charger_word[15:14] <= chg_ripple;
      engine1_word        <= eng1_flags;
      engine2_word        <= eng2_flags;
    end
  end

  // =====================================================
  // register writes and interrupt status
  // a new event in the clearing cycle survives: set wins over clear
  reg  [2:0] events;
  always @* begin
    events                     = 3'h0;
    events[`GVF_IRQ_DAY_BIT]   = day_wrap;
    events[`GVF_IRQ_SHUT_BIT]  = shut_now & ~shut_prev_reg;
    events[`GVF_IRQ_DEPTH_BIT] = deep_now & ~deep_prev_reg;
  end

  wire [2:0] w1c       = wr_stat ? pwdata[2:0] : 3'h0;
  wire [2:0] stat_next = (irq_stat_reg & ~w1c) | events;

  // =====================================================
  // interrupt line, registered so it comes straight from a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_next & irq_mask_reg);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg      <= `GVF_CTRL_RST;
      irq_stat_reg  <= 3'h0;
      irq_mask_reg  <= 3'h0;
      angle_in_reg  <= 32'h0;
      temp_in_reg   <= 32'h0;
      depth_in_reg  <= 32'h0;
      depth_flg_reg <= `GVF_DFLG_RST;
      chg_in_reg    <= 16'h0;
      eng1_in_reg   <= 16'h0;
      eng2_in_reg   <= 16'h0;
      shut_prev_reg <= 1'b0;
      deep_prev_reg <= 1'b0;
    end else begin
      shut_prev_reg <= shut_now;
      deep_prev_reg <= deep_now;
      irq_stat_reg  <= stat_next;
      if (wr_en) begin
        case (paddr)
          `GVF_CTRL_OFS:      ctrl_reg      <= pwdata;
          `GVF_IRQ_MASK_OFS:  irq_mask_reg  <= pwdata[2:0];
          `GVF_ANGLE_IN_OFS:  angle_in_reg  <= pwdata;
          `GVF_TEMP_IN_OFS:   temp_in_reg   <= pwdata;
          `GVF_DEPTH_IN_OFS:  depth_in_reg  <= pwdata;
          `GVF_DEPTH_FLG_OFS: depth_flg_reg <= pwdata[1:0];
          `GVF_CHG_IN_OFS:    chg_in_reg    <= pwdata[15:0];
          `GVF_ENG1_IN_OFS:   eng1_in_reg   <= pwdata[15:0];
          `GVF_ENG2_IN_OFS:   eng2_in_reg   <= pwdata[15:0];
          default: begin
          end
        endcase
      end
    end
  end

  // =====================================================
  // apb read mux, no wait state: data latched in the setup cycle
  reg [31:0] rd_next;
  reg        err_next;
  always @* begin
    rd_next  = 32'h0;
    err_next = 1'b0;
    case (paddr)
      `GVF_CTRL_OFS:      rd_next = ctrl_reg;
      `GVF_IRQ_STAT_OFS:  rd_next = {29'h0, irq_stat_reg};
      `GVF_IRQ_MASK_OFS:  rd_next = {29'h0, irq_mask_reg};
      `GVF_ANGLE_IN_OFS:  rd_next = angle_in_reg;
      `GVF_TEMP_IN_OFS:   rd_next = temp_in_reg;
      `GVF_DEPTH_IN_OFS:  rd_next = depth_in_reg;
      `GVF_DEPTH_FLG_OFS: rd_next = {30'h0, depth_flg_reg};
      `GVF_CHG_IN_OFS:    rd_next = {16'h0, chg_in_reg};
      `GVF_ENG1_IN_OFS:   rd_next = {16'h0, eng1_in_reg};
      `GVF_ENG2_IN_OFS:   rd_next = {16'h0, eng2_in_reg};
      `GVF_TOD_OFS:       rd_next = tod_word;
      `GVF_DATE_OFS:      rd_next = {16'h0, date_word};
      `GVF_ANGLE_OUT_OFS: rd_next = {angle_unsigned_word, angle_signed_word};
      `GVF_TFINE_OFS:     rd_next = {8'h0, temp_fine_word};
      `GVF_TMC_OFS:       rd_next = {temp_coarse_word, temp_medium_word};
      `GVF_DRANGE_OFS:    rd_next = {24'h0, depth_range_word};
      `GVF_CHG_OUT_OFS:   rd_next = {16'h0, charger_word};
      `GVF_ENG_OUT_OFS:   rd_next = {engine2_word, engine1_word};
      default:            err_next = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & err_next;
      if (setup) begin
        prdata <= pwrite ? 32'h0 : rd_next;
      end
    end
  end

endmodule
`default_nettype wire

/* File: bench/gvf_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module gvf_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic [31:0] tod_word,
  input wire logic [15:0] engine2_word
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // =====================================================
  // bus answer
  wire wr_acc = psel && penable && pready && pwrite;
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_has_cause: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  a_err_decode: assert property (pready |-> pslverr == (paddr > 8'h44 || paddr[1:0] != 2'h0))
    else $error("pslverr disagrees with address");
  a_write_rdata_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("prdata not zero on write");
  // =====================================================
  // formatted words
  a_eng2_upper_zero: assert property (engine2_word[15:8] == 8'h00)
    else $error("unassigned engine bits set");
  a_tod_in_day: assert property (tod_word < 32'd864000)
    else $error("time of day beyond one day");
  // writes land one edge after the access; the two edges after an access are excused
  a_tod_step_one: assert property ($changed(tod_word) && !$past(wr_acc) && !$past(wr_acc, 2)
    |-> tod_word == $past(tod_word) + 32'h1 || tod_word == 32'h0)
    else $error("time of day jumped");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pready && pslverr);
  c_wrap: cover property (tod_word == 32'h0 && $past(tod_word) != 32'h0);
endmodule
bind gvf_codec gvf_sva sva_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .irq, .tod_word, .engine2_word);
`default_nettype wire

/* File: bench/gvf_poller.sv */
`timescale 1ns/1ps
`default_nettype none
module gvf_poller (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output var  logic [7:0]  paddr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [31:0] pwdata
);
  int tmo = 0;
  initial begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end
  // =====================================================
  // one transfer; the idle edge at the end keeps drivers single-assigned
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 64) begin
      @(posedge pclk);
      n++;
    end
    if (n == 64) tmo++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  wire  [7:0]  paddr;
  wire  [31:0] pwdata, prdata;
  wire         psel, penable, pwrite, pready, pslverr, irq;
  int          fail_count = 0;
  int          check_count = 0;
  int          i;
  logic [31:0] q;
  logic        e;
  logic [15:0] d;
  // write addr, write data, read addr, expected
  logic [79:0] tab [11] = '{
    {8'h0C, 32'd12345, 8'h30, 32'h007B007B},
    {8'h0C, 32'hFFFFCFC7, 8'h30, 32'hF4F4FF85},
    {8'h10, 32'd25000, 8'h34, 32'h00048CA6},
    {8'h10, 32'd25000, 8'h38, 32'h0BA57477},
    {8'h10, 32'hFFFBD4F2, 8'h34, 32'h0},
    {8'h18, 32'h0, 8'h3C, 32'h0},
    {8'h14, 32'd252000, 8'h3C, 32'hFC},
    {8'h14, 32'd253000, 8'h3C, 32'hFD},
    {8'h18, 32'h1, 8'h3C, 32'hFE},
    {8'h18, 32'h3, 8'h3C, 32'hFF},
    {8'h18, 32'h2, 8'h3C, 32'hFF}};
  gvf_codec #(.TICK_CYC(4)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .angle_signed_word(),
    .angle_unsigned_word(), .temp_fine_word(), .temp_medium_word(), .temp_coarse_word(),
    .depth_range_word(), .date_word(), .tod_word(), .charger_word(), .engine1_word(),
    .engine2_word());
  gvf_poller poller_u (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata));
  initial forever #2.5 pclk = ~pclk;
  // =====================================================
  // tasks
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  task tally_and_finish;
    fail_count += poller_u.tmo;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    poller_u.xfer(1'b1, a, v, q, e);
    if (poller_u.tmo != 0) tally_and_finish;
  endtask
  task rd(input logic [7:0] a);
    poller_u.xfer(1'b0, a, 32'h0, q, e);
    if (poller_u.tmo != 0) tally_and_finish;
  endtask
  initial begin
    #400000;
    fail_count++;
    tally_and_finish;
  end
  // =====================================================
  // sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h3C);
    chk("depth_reset", 32'hFF, q);
    for (i = 0; i < 11; i++) begin
      wr(tab[i][79:72], tab[i][71:40]);
      rd(tab[i][39:32]);
      chk("format_word", tab[i][31:0], q);
    end
    $display("test formats done");
    for (i = 0; i <= 10; i++) begin
      d = {i[1:0], i[2:1], i[3:2], ~i[1:0], i[7:0]};
      wr(8'h1C, {16'h0, d});
      rd(8'h40);
      chk("charger", {16'h0, d}, q);
    end
    $display("test charger done");
    for (i = 0; i < 16; i++) begin
      d = 16'h1 << i;
      wr(8'h20, {16'h0, d});
      wr(8'h24, {16'h0, ~d});
      rd(8'h44);
      chk("engine", {~d & 16'h00FF, d}, q);
    end
    $display("test engine done");
    rd(8'h04);
    chk("status_events", 32'h6, q);
    chk("irq_masked", 32'h0, irq);
    wr(8'h04, 32'h7);
    wr(8'h00, 32'h0);
    wr(8'h28, 32'd863999);
    wr(8'h2C, 32'd100);
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h1);
    i = 0;
    while (irq !== 1'b1 && i < 200) begin
      @(posedge pclk);
      i++;
    end
    if (i == 200) begin
      fail_count++;
      tally_and_finish;
    end
    wr(8'h00, 32'h0);
    rd(8'h2C);
    chk("date", 32'd101, q);
    rd(8'h28);
    chk("tod_wrapped", 32'h1, q < 32'd20);
    rd(8'h04);
    chk("status", 32'h1, q);
    wr(8'h04, 32'h1);
    @(posedge pclk);
    chk("irq_cleared", 32'h0, irq);
    $display("test day wrap done");
    rd(8'h80);
    chk("unmapped_err", 32'h1, e);
    chk("unmapped_data", 32'h0, q);
    $display("test bus done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
